/* File: logic/sku_pkg.sv */
/*
 * Shared constants and carrier types for the shaped keying and update
 * synchronisation block: register offsets, field positions, reset values,
 * keying modes and the AXI4-Lite request and response bundles.
 * Assumes a single 10 MHz system clock and a 32-bit AXI4-Lite master.
 */
// Overview of operation
// - keying enable scales output, clear bypasses
// - internal bit picks auto or manual mode
// - keying enable resets to zero
// - auto scale is 14-bit counter, timer paced
// - keying pin high ramps up, low down
// - scale factor is unsigned, zero to 16383
// - top scale bits pick step 1,2,4,8
// - auto ramp never exceeds scale register value
// - ramp timer reloads and steps at one
// - keying pin change reloads ramp timer
// - load bit reloads timer on update/profile
// - entering auto mode reloads ramp timer
// - manual mode applies scale register at update
// - sync clock is system clock over four
// - update pin sampled on sync edges, edge-detected
// - update pulse copies buffers into active registers
// - auto sync aligns phase to sync input
// - software sync bit advances edge, self-clears
// - hardware sync bit: input edges advance clock
package sku_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] SKU_OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] SKU_OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] SKU_OFS_SCALE = 8'h08;
	localparam logic [7:0] SKU_OFS_RAMP = 8'h0c;
	localparam logic [7:0] SKU_OFS_STATUS = 8'h10;
	localparam logic [31:0] SKU_RST_WORD = 32'h0000_0000;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SKU_B_LOAD_TIMER = 26;
	localparam int SKU_B_KEY_EN = 25;
	localparam int SKU_B_KEY_AUTO = 24;
	localparam int SKU_B_AUTO_SYNC = 23;
	localparam int SKU_B_SW_SYNC = 22;
	localparam int SKU_B_HS_SYNC = 11;
	localparam int SKU_B_HW_SYNC = 10;
	localparam int SKU_SCALE_W = 14;
	localparam int SKU_RATE_W = 8;
	localparam int SKU_STEP_LSB = 14;
	localparam int SKU_PIN_N = 5;
	localparam int SKU_PIN_KEY = 0;
	localparam int SKU_PIN_UPD = 1;
	localparam int SKU_PIN_SYNC = 2;
	localparam int SKU_PIN_PROF = 3;

	// ----------------------------------------
	// timing and bus response codes
	// ----------------------------------------
	localparam logic [1:0] SKU_SYNC_RISE_PHASE = 2'h2;
	localparam logic [1:0] SKU_DIV_STEP = 2'h1;
	localparam logic [1:0] SKU_DIV_ADVANCE = 2'h2;
	localparam logic [1:0] SKU_AXI_OKAY = 2'h0;
	localparam logic [1:0] SKU_AXI_SLVERR = 2'h2;

	// keying modes of the data path scaler
	typedef enum logic [2:0] {
		SKU_MODE_BYPASS = 3'h1,
		SKU_MODE_MANUAL = 3'h2,
		SKU_MODE_AUTO = 3'h4
	} sku_mode_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} sku_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sku_axi_rsp_t;

endpackage

/* File: logic/sku_shaped_keying.sv */
/*
 * Shaped amplitude keying with update-strobe register transfer and sync
 * clock generation, including the three multi-device alignment modes.
 * Assumes ref_clk is the system clock, pins are asynchronous to it, and an
 * AXI4-Lite master writes the buffered registers.
 */
`timescale 1ns/1ps
module sku_shaped_keying
	import sku_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire sku_axi_req_t axi_req,
	output sku_axi_rsp_t axi_rsp,
	input wire logic keying_input_pin,
	input wire logic update_pin,
	input wire logic sync_in_pin,
	input wire logic [1:0] profile_pin,
	input wire logic [SKU_SCALE_W-1:0] core_data,
	output logic [SKU_SCALE_W-1:0] scaled_data,
	output logic [SKU_SCALE_W-1:0] scale_factor,
	output logic sync_clk_out
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_w[i*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [SKU_PIN_N-1:0] pin_raw;
	logic [SKU_PIN_N-1:0] pin_s1_q;
	logic [SKU_PIN_N-1:0] pin_s2_q;
	logic [SKU_PIN_N-1:0] pin_s3_q;
	logic [SKU_PIN_N-1:0] pin_q;
	logic [SKU_PIN_N-1:0] pin_prev_q;

	assign pin_raw = {profile_pin, sync_in_pin, update_pin, keying_input_pin};

	// a pin counts as changed only once stages two and three agree
	generate
		for (genvar g = 0; g < SKU_PIN_N; g++)
		begin : g_pin
			always_ff @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					pin_s1_q[g] <= 1'b0;
					pin_s2_q[g] <= 1'b0;
					pin_s3_q[g] <= 1'b0;
					pin_q[g] <= 1'b0;
					pin_prev_q[g] <= 1'b0;
				end
				else
				begin
					pin_s1_q[g] <= pin_raw[g];
					pin_s2_q[g] <= pin_s1_q[g];
					pin_s3_q[g] <= pin_s2_q[g];
					if (pin_s2_q[g] == pin_s3_q[g])
						pin_q[g] <= pin_s3_q[g];
					pin_prev_q[g] <= pin_q[g];
				end
			end
		end
	endgenerate

	wire key_pin = pin_q[SKU_PIN_KEY];
	wire key_change = pin_q[SKU_PIN_KEY] ^ pin_prev_q[SKU_PIN_KEY];
	wire sync_in_rise = pin_q[SKU_PIN_SYNC] & ~pin_prev_q[SKU_PIN_SYNC];
	wire prof_change = |(pin_q[SKU_PIN_PROF +: 2] ^ pin_prev_q[SKU_PIN_PROF +: 2]);

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	sku_axi_rsp_t rsp_q;
	logic [31:0] buf_one_q;
	logic [31:0] buf_two_q;
	logic [31:0] buf_scale_q;
	logic [31:0] buf_ramp_q;
	logic sw_sync_q;
	logic [31:0] rd_word;
	logic rd_hit;

	wire aw_take = axi_req.awvalid & rsp_q.awready;
	wire w_take = axi_req.wvalid & rsp_q.wready;
	wire wr_go = aw_held_q & w_held_q & ~rsp_q.bvalid;
	wire wr_one = wr_go & addr_hit(aw_addr_q, SKU_OFS_CTRL_ONE);
	wire wr_two = wr_go & addr_hit(aw_addr_q, SKU_OFS_CTRL_TWO);
	wire wr_scale = wr_go & addr_hit(aw_addr_q, SKU_OFS_SCALE);
	wire wr_ramp = wr_go & addr_hit(aw_addr_q, SKU_OFS_RAMP);
	wire wr_bad = wr_go & ~(wr_one | wr_two | wr_scale | wr_ramp);
	wire [31:0] one_merged = merge_bytes(buf_one_q, w_data_q, w_strb_q);
	wire rd_take = axi_req.arvalid & rsp_q.arready;

	// address and data are held independently; the answer follows both
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			rsp_q <= '0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held_q <= 1'b1;
				aw_addr_q <= axi_req.awaddr;
			end
			else if (wr_go)
				aw_held_q <= 1'b0;
			if (w_take)
			begin
				w_held_q <= 1'b1;
				w_data_q <= axi_req.wdata;
				w_strb_q <= axi_req.wstrb;
			end
			else if (wr_go)
				w_held_q <= 1'b0;
			rsp_q.awready <= ~aw_held_q & ~aw_take;
			rsp_q.wready <= ~w_held_q & ~w_take;
			if (wr_go)
			begin
				rsp_q.bvalid <= 1'b1;
				rsp_q.bresp <= wr_bad ? SKU_AXI_SLVERR : SKU_AXI_OKAY;
			end
			else if (axi_req.bready)
				rsp_q.bvalid <= 1'b0;
			rsp_q.arready <= ~rsp_q.rvalid & ~rd_take;
			if (rd_take)
			begin
				rsp_q.rvalid <= 1'b1;
				rsp_q.rdata <= rd_word;
				rsp_q.rresp <= rd_hit ? SKU_AXI_OKAY : SKU_AXI_SLVERR;
			end
			else if (axi_req.rready)
				rsp_q.rvalid <= 1'b0;
		end
	end

	assign axi_rsp = rsp_q;

	// ----------------------------------------
	// buffered registers
	// ----------------------------------------
	// the software sync bit never stores: it fires once and reads as zero
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			buf_one_q <= SKU_RST_WORD;
			buf_two_q <= SKU_RST_WORD;
			buf_scale_q <= SKU_RST_WORD;
			buf_ramp_q <= SKU_RST_WORD;
			sw_sync_q <= 1'b0;
		end
		else
		begin
			sw_sync_q <= wr_one & one_merged[SKU_B_SW_SYNC];
			if (wr_one)
			begin
				buf_one_q <= one_merged;
				buf_one_q[SKU_B_SW_SYNC] <= 1'b0;
			end
			if (wr_two)
				buf_two_q <= merge_bytes(buf_two_q, w_data_q, w_strb_q);
			if (wr_scale)
				buf_scale_q <= merge_bytes(buf_scale_q, w_data_q, w_strb_q);
			if (wr_ramp)
				buf_ramp_q <= merge_bytes(buf_ramp_q, w_data_q, w_strb_q);
		end
	end

	// ----------------------------------------
	// sync clock divider
	// ----------------------------------------
	logic [1:0] div_q;
	logic sync_en_q;
	logic sync_clk_q;
	logic [31:0] act_one_q;
	logic [31:0] act_two_q;
	logic [15:0] act_scale_q;
	logic [SKU_RATE_W-1:0] act_ramp_q;

	wire auto_sync = act_one_q[SKU_B_AUTO_SYNC];
	wire hw_sync = act_two_q[SKU_B_HW_SYNC];
	// auto mode nudges one system clock per master edge until phases meet
	wire auto_adv = auto_sync & sync_in_rise & (div_q != SKU_SYNC_RISE_PHASE);
	wire hw_adv = hw_sync & sync_in_rise;
	wire advance = sw_sync_q | hw_adv | auto_adv;
	wire [1:0] div_d = div_q + (advance ? SKU_DIV_ADVANCE : SKU_DIV_STEP);

	// divide by four; skipping a count moves the rising edge one cycle earlier
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			div_q <= 2'h0;
			sync_clk_q <= 1'b0;
			sync_en_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			sync_clk_q <= div_d[1];
			sync_en_q <= div_d[1] & ~div_q[1];
		end
	end

	assign sync_clk_out = sync_clk_q;

	// ----------------------------------------
	// update strobe and register transfer
	// ----------------------------------------
	logic upd_smp_q;
	logic upd_pulse_q;

	// sampled on sync edges only, so a transfer lands at a fixed sysclk phase
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			upd_smp_q <= 1'b0;
			upd_pulse_q <= 1'b0;
		end
		else
		begin
			if (sync_en_q)
				upd_smp_q <= pin_q[SKU_PIN_UPD];
			upd_pulse_q <= sync_en_q & pin_q[SKU_PIN_UPD] & ~upd_smp_q;
		end
	end

	// active copies change only on the update pulse
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			act_one_q <= SKU_RST_WORD;
			act_two_q <= SKU_RST_WORD;
			act_scale_q <= 16'h0000;
			act_ramp_q <= 8'h00;
		end
		else if (upd_pulse_q)
		begin
			act_one_q <= buf_one_q;
			act_two_q <= buf_two_q;
			act_scale_q <= buf_scale_q[15:0];
			act_ramp_q <= buf_ramp_q[SKU_RATE_W-1:0];
		end
	end

	// ----------------------------------------
	// keying mode and ramp timer
	// ----------------------------------------
	sku_mode_t mode;
	logic auto_prev_q;
	logic [SKU_RATE_W-1:0] timer_q;
	logic [SKU_SCALE_W-1:0] ramp_q;

	// auto bit is ignored whenever keying itself is off
	assign mode = !act_one_q[SKU_B_KEY_EN] ? SKU_MODE_BYPASS :
		act_one_q[SKU_B_KEY_AUTO] ? SKU_MODE_AUTO : SKU_MODE_MANUAL;

	wire auto_on = (mode == SKU_MODE_AUTO);
	wire auto_enter = auto_on & ~auto_prev_q;
	wire forced_load = key_change | auto_enter |
		(act_one_q[SKU_B_LOAD_TIMER] & (upd_pulse_q | prof_change));
	// a rate of zero behaves as one so the timer can never stall
	wire timer_end = (timer_q <= 8'h01);
	wire step_en = auto_on & sync_en_q & timer_end & ~forced_load;
	wire [3:0] step = 4'h1 << act_scale_q[SKU_STEP_LSB +: 2];
	wire [SKU_SCALE_W-1:0] ceiling = act_scale_q[SKU_SCALE_W-1:0];
	wire [SKU_SCALE_W:0] up_sum = {1'b0, ramp_q} + {11'h000, step};
	wire [SKU_SCALE_W-1:0] up_val = (up_sum > {1'b0, ceiling}) ? ceiling :
		up_sum[SKU_SCALE_W-1:0];
	wire [SKU_SCALE_W-1:0] dn_val = (ramp_q > {10'h000, step}) ?
		ramp_q - {10'h000, step} : 14'h0000;

	// the timer counts at the sync rate and reloads from the rate setting
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			auto_prev_q <= 1'b0;
			timer_q <= 8'h00;
		end
		else
		begin
			auto_prev_q <= auto_on;
			if (forced_load)
				timer_q <= act_ramp_q;
			else if (auto_on & sync_en_q)
				timer_q <= timer_end ? act_ramp_q : timer_q - 8'h01;
		end
	end

	// ----------------------------------------
	// auto scale counter
	// ----------------------------------------
	// ramps up to the programmed ceiling or down to zero, never wrapping either way
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			ramp_q <= 14'h0000;
		else if (step_en)
			ramp_q <= key_pin ? up_val : dn_val;
		else if (auto_on & (ramp_q > ceiling))
			ramp_q <= ceiling;
	end

	// ----------------------------------------
	// data path scaler
	// ----------------------------------------
	logic [SKU_SCALE_W-1:0] sel_scale;
	logic [2*SKU_SCALE_W-1:0] product;
	logic [SKU_SCALE_W-1:0] scaled_q;
	logic [SKU_SCALE_W-1:0] scale_q;

	always_comb
	begin
		case (mode)
			SKU_MODE_AUTO: sel_scale = ramp_q;
			SKU_MODE_MANUAL: sel_scale = act_scale_q[SKU_SCALE_W-1:0];
			SKU_MODE_BYPASS: sel_scale = 14'h3fff;
			default: sel_scale = 14'h3fff;
		endcase
	end

	// unsigned product; the top half is the scaled sample
	assign product = core_data * sel_scale;

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			scaled_q <= 14'h0000;
			scale_q <= 14'h0000;
		end
		else
		begin
			scaled_q <= (mode == SKU_MODE_BYPASS) ? core_data :
				product[2*SKU_SCALE_W-1 -: SKU_SCALE_W];
			scale_q <= sel_scale;
		end
	end

	assign scaled_data = scaled_q;
	assign scale_factor = scale_q;

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire rd_one = addr_hit(axi_req.araddr, SKU_OFS_CTRL_ONE);
	wire rd_two = addr_hit(axi_req.araddr, SKU_OFS_CTRL_TWO);
	wire rd_scale = addr_hit(axi_req.araddr, SKU_OFS_SCALE);
	wire rd_ramp = addr_hit(axi_req.araddr, SKU_OFS_RAMP);
	wire rd_stat = addr_hit(axi_req.araddr, SKU_OFS_STATUS);
	assign rd_hit = rd_one | rd_two | rd_scale | rd_ramp | rd_stat;
	wire [31:0] stat_word = {2'h0, div_q, timer_q, 1'b0, auto_on, ramp_q, 2'h0, key_pin,
		upd_smp_q};
	// unmapped offsets read as zero
	assign rd_word = rd_one ? buf_one_q : rd_two ? buf_two_q :
		rd_scale ? buf_scale_q : rd_ramp ? buf_ramp_q : rd_stat ? stat_word : 32'h0;

endmodule

/* File: verif/sku_checker.sv */
/*
 * Checker for the shaped keying block: bus handshakes, response codes,
 * sync clock spacing and the keying state after reset.
 * Assumes it is bound to sku_shaped_keying and sees only its ports.
 */
`timescale 1ns/1ps
module sku_checker
	import sku_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire sku_axi_req_t axi_req,
	input wire sku_axi_rsp_t axi_rsp,
	input wire logic [SKU_SCALE_W-1:0] scale_factor,
	input wire logic sync_clk_out
);
	logic ar_map;
	logic aw_map;
	logic ar_ok_q;
	logic aw_ok_q;
	// mirrored read decode, reused for writes, so the response code can be judged later
	assign ar_map = axi_req.araddr <= SKU_OFS_STATUS && axi_req.araddr[1:0] == 2'h0;
	assign aw_map = axi_req.awaddr <= SKU_OFS_STATUS && axi_req.awaddr[1:0] == 2'h0;
	// decode of the address offered at each edge
	always_ff @(posedge ref_clk)
	begin
		ar_ok_q <= ar_map;
		aw_ok_q <= aw_map;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	sequence ar_take;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	sequence wr_take;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence resp_late;
		!axi_rsp.bvalid ##1 axi_rsp.bvalid;
	endsequence
	// an advance shortens one period to three cycles, never more
	sync_rise_a: assert property ($rose(sync_clk_out) |-> ##[3:4] $rose(sync_clk_out))
		else $error("sync clock rises not three or four cycles apart");
	sync_fall_a: assert property ($fell(sync_clk_out) |-> ##[3:4] $fell(sync_clk_out))
		else $error("sync clock falls not three or four cycles apart");
	key_off_a: assert property ($fell(reset) |-> ##2 scale_factor == 14'h3fff)
		else $error("keying not bypassed after reset");
	b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
		else $error("write response dropped early");
	r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
		|=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped early");
	r_time_a: assert property (ar_take |=> axi_rsp.rvalid && (ar_ok_q ? axi_rsp.rresp
		== SKU_AXI_OKAY : axi_rsp.rresp == SKU_AXI_SLVERR && axi_rsp.rdata == 32'h0))
		else $error("read answer late or wrong code");
	ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read address taken during answer");
	w_resp_a: assert property (wr_take |=> resp_late ##0 axi_rsp.bresp ==
		($past(aw_ok_q) ? SKU_AXI_OKAY : SKU_AXI_SLVERR))
		else $error("write answer late or wrong code");
	w_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken during answer");
endmodule

bind sku_shaped_keying sku_checker chk_u (.ref_clk(ref_clk), .reset(reset),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .scale_factor(scale_factor),
	.sync_clk_out(sync_clk_out));

/* File: verif/sku_host_model.sv */
/*
 * Host-side model: raises the update pin aligned to the device sync clock
 * and can stand in for a master device's sync clock.
 * Assumes the same system clock as the device.
 */
`timescale 1ns/1ps
module sku_host_model
	import sku_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic sync_clk_out,
	input wire logic upd_go,
	input wire logic master_en,
	output logic update_pin,
	output logic sync_in_pin,
	output logic busy
);
	logic [4:0] cnt_q;
	logic [1:0] div_q;
	logic sync_prev_q;
	logic sync_rise;
	assign sync_rise = sync_clk_out && !sync_prev_q;
	assign busy = cnt_q != 5'h0;
	// master clock stands still low when off; update rises just after a device
	// sync edge so it is settled at the next one, and stays low 11 cycles after
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			{cnt_q, div_q, sync_prev_q, update_pin, sync_in_pin} <= '0;
		end
		else
		begin
			sync_prev_q <= sync_clk_out;
			div_q <= div_q + 2'h1;
			sync_in_pin <= master_en && div_q[1];
			if (cnt_q == 5'h0)
				cnt_q <= {4'h0, upd_go};
			else if (cnt_q != 5'h1 || sync_rise)
				cnt_q <= (cnt_q == 5'h10) ? 5'h0 : cnt_q + 5'h1;
			if (cnt_q == 5'h1 && sync_rise)
				update_pin <= 1'b1;
			if (cnt_q == 5'h5)
				update_pin <= 1'b0;
		end
	end
endmodule

/* File: verif/shaped_keying_and_update_sync_tb.sv */
/*
 * Self-checking bench for the shaped keying block: register access, bypass,
 * manual and automatic keying, update transfer and the three sync modes.
 * Assumes the host model drives the update and sync input pins.
 */
`timescale 1ns/1ps
module shaped_keying_and_update_sync_tb
	import sku_pkg::*;
;
	logic ref_clk;
	logic reset;
	sku_axi_req_t req;
	sku_axi_rsp_t rsp;
	logic key;
	logic upd;
	logic sin;
	logic go;
	logic men;
	logic busy;
	logic sclk;
	logic [13:0] core;
	logic [13:0] sd;
	logic [13:0] sf;
	logic [31:0] d;
	logic [13:0] s;
	logic [13:0] prev;
	int errors;
	int n_tests;
	int cyc;
	int t0;
	int t1;
	int t2;
	int r;
	sku_shaped_keying dut_u (.ref_clk(ref_clk), .reset(reset), .axi_req(req),
		.axi_rsp(rsp), .keying_input_pin(key), .update_pin(upd), .sync_in_pin(sin),
		.profile_pin(2'h0), .core_data(core), .scaled_data(sd), .scale_factor(sf),
		.sync_clk_out(sclk));
	sku_host_model host_u (.ref_clk(ref_clk), .reset(reset), .sync_clk_out(sclk),
		.upd_go(go), .master_en(men), .update_pin(upd), .sync_in_pin(sin), .busy(busy));
	// clock and a free cycle count read on rising edges
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) cyc <= cyc + 1;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// each channel released at the edge where it is taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge ref_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge ref_clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		req.bready <= 1'b0;
		if (n == 50) errors++;
	endtask
	task rd(input logic [7:0] a);
		int n;
		@(posedge ref_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge ref_clk);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) break;
		end
		d = rsp.rdata;
		req.rready <= 1'b0;
		if (n == 50) errors++;
	endtask
	task upd_do;
		int n;
		@(posedge ref_clk);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		for (n = 0; n < 40; n++)
		begin
			@(posedge ref_clk);
			if (!busy) break;
		end
		repeat (4) @(posedge ref_clk);
	endtask
	task rise(output int t);
		int n;
		logic p;
		p = sclk;
		for (n = 0; n < 20; n++)
		begin
			@(posedge ref_clk);
			if (sclk && !p) break;
			p = sclk;
		end
		t = cyc;
	endtask
	// every change must be one step in the right way, one ramp period apart
	task ramp(input logic [13:0] tgt, input logic [13:0] st, input int per, input bit up);
		logic [13:0] last;
		int gap;
		int n;
		bit seen;
		last = sf;
		gap = 0;
		seen = 0;
		for (n = 0; n < 2000 && sf !== tgt; n++)
		begin
			@(posedge ref_clk);
			gap++;
			if (sf !== last)
			begin
				chk(up ? sf - last : last - sf, st);
				if (seen) chk(gap, per);
				seen = 1;
				gap = 0;
				last = sf;
			end
		end
		repeat (3 * per) @(posedge ref_clk);
		chk(sf, tgt);
	endtask
	function automatic logic [13:0] scaled(input logic [13:0] c, input logic [13:0] f);
		return 14'((28'(c) * 28'(f)) >> 14);
	endfunction
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		end_sim();
	end
	initial
	begin
		{errors, n_tests, cyc} = '0;
		{req, key, go, men} = '0;
		core = 14'h0;
		reset = 1'b1;
		void'($urandom(27438));
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		core <= 14'($urandom);
		repeat (4) @(posedge ref_clk);
		chk(sd, core);
		chk(sf, 14'h3fff);
		rd(SKU_OFS_CTRL_ONE);
		chk(d[SKU_B_KEY_EN], 1'b0);
		rd(8'h14);
		chk(d, 32'h0);
		wr(8'h18, 32'hffff_ffff);
		$display("test reset done");
		rise(t0);
		wr(SKU_OFS_CTRL_ONE, 32'h1 << SKU_B_SW_SYNC);
		rise(t1);
		rise(t2);
		chk(32'((t2 - t0) % 4), 32'h3);
		rd(SKU_OFS_CTRL_ONE);
		chk(d[SKU_B_SW_SYNC], 1'b0);
		wr(SKU_OFS_CTRL_TWO, (32'h1 << SKU_B_HW_SYNC) | (32'h1 << SKU_B_HS_SYNC));
		upd_do();
		men <= 1'b1;
		repeat (3) rise(t0);
		// one advance per master period: five rises every sixteen cycles
		repeat (5) rise(t1);
		chk(t1 - t0, 16);
		rd(SKU_OFS_CTRL_TWO);
		chk(d[SKU_B_HW_SYNC], 1'b1);
		wr(SKU_OFS_CTRL_TWO, 32'h0);
		wr(SKU_OFS_CTRL_ONE, 32'h1 << SKU_B_AUTO_SYNC);
		upd_do();
		repeat (8) rise(t0);
		rise(t1);
		chk(t1 - t0, 4);
		men <= 1'b0;
		$display("test sync done");
		wr(SKU_OFS_CTRL_ONE, 32'h1 << SKU_B_KEY_EN);
		prev = 14'h3fff;
		for (int i = 0; i < 3; i++)
		begin
			s = (i == 0) ? 14'h0 : (i == 1) ? 14'h3fff : 14'($urandom);
			core <= 14'($urandom);
			wr(SKU_OFS_SCALE, {18'h0, s});
			chk(sf, prev);
			upd_do();
			chk(sf, s);
			chk(sd, scaled(core, s));
			prev = s;
		end
		$display("test manual done");
		wr(SKU_OFS_CTRL_ONE, (32'h1 << SKU_B_KEY_EN) | (32'h1 << SKU_B_KEY_AUTO));
		for (int c = 0; c < 4; c++)
		begin
			s = 14'($urandom_range(1, 6) * 8);
			r = $urandom_range(1, 3);
			wr(SKU_OFS_SCALE, {16'h0, 2'(c), s});
			wr(SKU_OFS_RAMP, 32'(r));
			upd_do();
			key <= 1'b1;
			ramp(s, 14'h1 << c, 4 * r, 1);
			key <= 1'b0;
			ramp(14'h0, 14'h1 << c, 4 * r, 0);
		end
		$display("test auto done");
		end_sim();
	end
endmodule
